// ---- fcel_pkg.sv ----
// Constants for the flash command error-lock block
`default_nettype none
package fcel_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_ACC_STAT = 8'h00;
  localparam logic [7:0]  OFS_IRQ_EN   = 8'h04;
  localparam logic [7:0]  OFS_MODE     = 8'h08;
  localparam logic [7:0]  OFS_HVE      = 8'h0C;
  localparam logic [7:0]  OFS_SEQ_STAT = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ACC_DATA_BIT = 3;
  localparam int unsigned ACC_LOCK_BIT = 4;
  localparam int unsigned ACC_CODE_BIT = 7;
  localparam int unsigned IRQ_EN_BIT   = 4;
  localparam int unsigned HVE_BIT      = 0;
  localparam int unsigned RDY_BIT      = 15;
  // Error flag index inside the sequencer status word
  localparam int unsigned E_ILG = 0;
  localparam int unsigned E_ERS = 1;
  localparam int unsigned E_PRG = 2;
  localparam int unsigned E_WE  = 3;
  localparam int unsigned E_OTP = 4;
  localparam int unsigned E_CFG = 5;
  localparam int unsigned E_TBL = 6;
  localparam int unsigned E_FRW = 7;
  localparam int unsigned NERR  = 8;
  // ----------------------------------------------------------------
  // Mode values and command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_READ  = 16'h0000;
  localparam logic [15:0] MODE_CODE  = 16'h0001;
  localparam logic [15:0] MODE_DATA  = 16'h0080;
  localparam logic [7:0]  LAST_CODE  = 8'hD0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_MODE   = 16'h0000;
  localparam logic [7:0]  RST_ERR    = 8'h00;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- fcel_top.sv ----
// Command error detection and command-lock logic of the flash sequencer
//
// The address map and strobed register access were decided locally.
`default_nettype none
module fcel_top #(
  parameter int unsigned AW = 24
) (
  // Clock and reset
  input  wire  logic          clk,
  input  wire  logic          rstn,
  // Register port
  input  wire  logic [7:0]    reg_addr,
  input  wire  logic [31:0]   reg_wdata,
  input  wire  logic          reg_wr,
  input  wire  logic          reg_rd,
  output logic       [31:0]   reg_rdata,
  // Command issue area events
  input  wire  logic          cmd_first,
  input  wire  logic          cmd_undef,
  input  wire  logic          cmd_last,
  input  wire  logic [7:0]    cmd_last_data,
  input  wire  logic          cmd_is_dma,
  input  wire  logic          cmd_n_bad,
  input  wire  logic          cmd_mode_bad,
  input  wire  logic          cmd_blank_chk,
  input  wire  logic          blank_check_direction,
  input  wire  logic [AW-1:0] cmd_start_addr_reg,
  input  wire  logic [AW-1:0] cmd_end_addr_reg,
  input  wire  logic          cmd_status_clr,
  input  wire  logic          cmd_force_stop,
  input  wire  logic          cmd_suspend,
  input  wire  logic          cmd_resume,
  input  wire  logic          cmd_area_rd,
  // Target checks
  input  wire  logic          cf_rsv_hit,
  input  wire  logic          df_rsv_hit,
  input  wire  logic          cfgotp_rsv_hit,
  input  wire  logic          otp_blk_hit,
  input  wire  logic          auth_missing,
  // Operation results
  input  wire  logic          erase_fail,
  input  wire  logic          erase_lock_hit,
  input  wire  logic          prog_fail,
  input  wire  logic          prog_lock_hit,
  input  wire  logic [3:0]    ecc_2bit,
  // Sequencer state
  input  wire  logic          seq_ready_flag,
  input  wire  logic          op_busy,
  // Control outputs
  output logic                cmd_locked_flag,
  output logic                flash_access_err_irq,
  output logic                pe_reject,
  output logic                suspend_grant,
  output logic                op_abort,
  output logic                read_mode,
  output logic                hv_enable_ctrl_bit
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic mode_legal(input logic [15:0] m);
    mode_legal = (m == fcel_pkg::MODE_READ) || (m == fcel_pkg::MODE_CODE) ||
                 (m == fcel_pkg::MODE_DATA);
  endfunction

  // Strobe and address come in as arguments so every caller stays sensitive to them
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                       lock_ff;
  logic                       code_area_access_err_ff;
  logic                       data_area_access_err_ff;
  logic [fcel_pkg::NERR-1:0]  err_ff;
  logic                       irq_en_ff;
  logic                       irq_ff;
  logic [15:0]                mode_ff;
  logic [15:0]                susp_mode_ff;
  logic                       hve_ff;
  logic                       hve_prev_ff;
  logic [31:0]                rdata_ff;

  logic                       unlock;
  logic                       cmd_any;
  logic                       mode_bad_wr;
  logic                       resume_bad;
  logic                       bc_bad;
  logic                       last_bad;
  logic                       area_bad;
  logic                       cmd_errs;
  logic                       code_area_access_err_set;
  logic                       data_area_access_err_set;
  logic                       hv_drop;
  logic [fcel_pkg::NERR-1:0]  err_set;
  logic                       any_set;
  logic                       nxt_lock;
  logic [fcel_pkg::NERR-1:0]  nxt_err;

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  // Clear paths read the registered access flags, so an access error
  // raised in the same cycle still wins over the clear.
  assign unlock = (cmd_force_stop || (cmd_status_clr && seq_ready_flag)) &&
                  !code_area_access_err_ff && !data_area_access_err_ff;
  assign cmd_any = cmd_first || cmd_suspend || cmd_resume ||
                   cmd_status_clr || cmd_force_stop;
  assign mode_bad_wr = wr_hit(reg_wr, reg_addr, fcel_pkg::OFS_MODE) && !mode_legal(reg_wdata[15:0]);
  assign resume_bad  = cmd_resume && (mode_ff != susp_mode_ff);
  assign bc_bad = cmd_blank_chk && (blank_check_direction ?
                  (cmd_start_addr_reg < cmd_end_addr_reg) :
                  (cmd_start_addr_reg > cmd_end_addr_reg));
  assign last_bad = cmd_last && !cmd_is_dma && (cmd_last_data != fcel_pkg::LAST_CODE);
  // Issue area reads are illegal in every mode
  assign area_bad = cmd_area_rd || (cmd_first && read_mode);
  assign cmd_errs = cmd_undef || last_bad || cmd_n_bad || bc_bad ||
                    cmd_mode_bad || cf_rsv_hit || df_rsv_hit ||
                    cfgotp_rsv_hit || otp_blk_hit || auth_missing ||
                    resume_bad;
  assign code_area_access_err_set = !lock_ff && cf_rsv_hit;
  assign data_area_access_err_set = !lock_ff && (df_rsv_hit || cfgotp_rsv_hit);
  // Ready low stands for a command in progress
  assign hv_drop  = hve_prev_ff && !hve_ff && !seq_ready_flag;

  always_comb begin
    err_set = '0;
    // While locked, a new command may only raise the illegal flag
    err_set[fcel_pkg::E_ILG] = mode_bad_wr || area_bad ||
                               (lock_ff ? (cmd_any && !unlock) : cmd_errs);
    // Results of a running operation still land while locked
    err_set[fcel_pkg::E_ERS] = erase_fail || (!lock_ff && erase_lock_hit);
    err_set[fcel_pkg::E_PRG] = prog_fail || (!lock_ff && prog_lock_hit);
    err_set[fcel_pkg::E_WE]  = hv_drop;
    err_set[fcel_pkg::E_FRW] = ecc_2bit[0];
    err_set[fcel_pkg::E_OTP] = ecc_2bit[1];
    err_set[fcel_pkg::E_CFG] = ecc_2bit[2];
    err_set[fcel_pkg::E_TBL] = ecc_2bit[3];
  end

  assign any_set  = (|err_set) || code_area_access_err_set || data_area_access_err_set;
  assign nxt_lock = (lock_ff && !unlock) || any_set;
  assign nxt_err  = (unlock ? fcel_pkg::RST_ERR : err_ff) | err_set;

  // ----------------------------------------------------------------
  // Lock and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_ff <= 1'b0;
      err_ff  <= fcel_pkg::RST_ERR;
      code_area_access_err_ff <= 1'b0;
      data_area_access_err_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      err_ff  <= nxt_err;
      code_area_access_err_ff <= (code_area_access_err_ff && !unlock) || code_area_access_err_set;
      data_area_access_err_ff <= (data_area_access_err_ff && !unlock) || data_area_access_err_set;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_lock && irq_en_ff;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // An illegal mode value is stored anyway; the lock already blocks it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff   <= fcel_pkg::RST_MODE;
      irq_en_ff <= 1'b0;
      hve_ff    <= 1'b0;
    end else begin
      if (wr_hit(reg_wr, reg_addr, fcel_pkg::OFS_MODE)) begin
        mode_ff <= reg_wdata[15:0];
      end
      if (wr_hit(reg_wr, reg_addr, fcel_pkg::OFS_IRQ_EN)) begin
        irq_en_ff <= reg_wdata[fcel_pkg::IRQ_EN_BIT];
      end
      if (wr_hit(reg_wr, reg_addr, fcel_pkg::OFS_HVE)) begin
        hve_ff <= reg_wdata[fcel_pkg::HVE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hve_prev_ff  <= 1'b0;
      susp_mode_ff <= fcel_pkg::RST_MODE;
    end else begin
      hve_prev_ff <= hve_ff;
      if (suspend_grant) begin
        susp_mode_ff <= mode_ff;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= fcel_pkg::RST_RDATA;
    end else begin
      rdata_ff <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          fcel_pkg::OFS_ACC_STAT: begin
            rdata_ff[fcel_pkg::ACC_CODE_BIT] <= code_area_access_err_ff;
            rdata_ff[fcel_pkg::ACC_LOCK_BIT] <= lock_ff;
            rdata_ff[fcel_pkg::ACC_DATA_BIT] <= data_area_access_err_ff;
          end
          fcel_pkg::OFS_IRQ_EN: begin
            rdata_ff[fcel_pkg::IRQ_EN_BIT] <= irq_en_ff;
          end
          fcel_pkg::OFS_MODE: begin
            rdata_ff[15:0] <= mode_ff;
          end
          fcel_pkg::OFS_HVE: begin
            rdata_ff[fcel_pkg::HVE_BIT] <= hve_ff;
          end
          // Ready reported live; software polls it for command end
          fcel_pkg::OFS_SEQ_STAT: begin
            rdata_ff[fcel_pkg::RDY_BIT] <= seq_ready_flag;
            rdata_ff[fcel_pkg::NERR-1:0] <= err_ff;
          end
          default: begin
            rdata_ff <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata            = rdata_ff;
  assign cmd_locked_flag      = lock_ff;
  assign flash_access_err_irq = irq_ff;
  assign pe_reject            = lock_ff;
  // Lock never aborts a running operation; only forced stop does
  assign op_abort             = cmd_force_stop;
  // Suspend refused outright while locked, so the running job finishes
  assign suspend_grant        = cmd_suspend && op_busy && !lock_ff;
  assign read_mode            = (mode_ff == fcel_pkg::MODE_READ);
  assign hv_enable_ctrl_bit   = hve_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_error_locks: assert property (any_set |=> lock_ff)
    else $error("error did not lock");
  a_unlock_cause: assert property ($fell(lock_ff) |->
    $past(cmd_force_stop || (cmd_status_clr && seq_ready_flag)) &&
    !$past(code_area_access_err_ff) && !$past(data_area_access_err_ff))
    else $error("lock left without valid clear");
  a_busy_clear_ignored: assert property (lock_ff && cmd_status_clr &&
    !seq_ready_flag && !cmd_force_stop |=> lock_ff)
    else $error("status clear honoured while busy");
  a_stop_any_ready: assert property (lock_ff && cmd_force_stop && !code_area_access_err_ff &&
    !data_area_access_err_ff && !any_set |=> !lock_ff && err_ff == '0)
    else $error("forced stop not honoured");
  // Enable as seen before the edge, matching the registered interrupt
  a_irq_on_lock: assert property ($rose(lock_ff) && $past(irq_en_ff) |-> flash_access_err_irq)
    else $error("lock interrupt missing");
  a_no_suspend_locked: assert property (lock_ff |-> !suspend_grant)
    else $error("suspend granted while locked");
  a_locked_cmd_ilg: assert property (lock_ff && cmd_first && !unlock
    |=> err_ff[fcel_pkg::E_ILG] && $stable(code_area_access_err_ff) && $stable(data_area_access_err_ff))
    else $error("locked command handling wrong");
  a_mode_illegal: assert property (mode_bad_wr |=> lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("bad mode value not flagged");
  a_last_not_d0: assert property (cmd_last && !cmd_is_dma && !lock_ff &&
    cmd_last_data != fcel_pkg::LAST_CODE |=> err_ff[fcel_pkg::E_ILG])
    else $error("bad final write not flagged");
  a_erase_flag: assert property (erase_fail |=> err_ff[fcel_pkg::E_ERS] ##1
    (err_ff[fcel_pkg::E_ERS] || $past(unlock)))
    else $error("erase error not held");
  a_hv_drop: assert property (hve_prev_ff && !hve_ff && !seq_ready_flag
    |=> err_ff[fcel_pkg::E_WE] && lock_ff)
    else $error("write enable drop not flagged");
  a_read_mode: assert property (reg_wr && reg_addr == fcel_pkg::OFS_MODE &&
    reg_wdata[15:0] == fcel_pkg::MODE_READ |=> read_mode)
    else $error("read mode not entered");

  // ----------------------------------------------------------------
  // Error source assertions
  // ----------------------------------------------------------------
  // Sources that the lock masks are checked from an unlocked start, so the locked-state
  // masking of new commands cannot hide a missing lock; a set in the
  // same cycle as a clear must still leave the flag standing.
  a_undef_locks: assert property (!lock_ff && cmd_undef |=> lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("undefined command not flagged");
  a_count_locks: assert property (!lock_ff && cmd_n_bad |=> lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("bad word count not flagged");
  a_blank_dir: assert property (!lock_ff && cmd_blank_chk &&
    (blank_check_direction ? !(cmd_start_addr_reg >= cmd_end_addr_reg) :
    !(cmd_start_addr_reg <= cmd_end_addr_reg)) |=> lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("blank check direction not flagged");
  a_mode_reject: assert property (!lock_ff && cmd_mode_bad |=> lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("command in wrong mode not flagged");
  a_erase_protect: assert property (!lock_ff && erase_lock_hit |=> lock_ff && err_ff[fcel_pkg::E_ERS])
    else $error("protected erase not flagged");
  a_prog_protect: assert property (prog_fail || (!lock_ff && prog_lock_hit) |=>
    lock_ff && err_ff[fcel_pkg::E_PRG])
    else $error("program error not flagged");
  a_ecc_sources: assert property (ecc_2bit != 4'h0 |=> lock_ff &&
    ({err_ff[fcel_pkg::E_TBL], err_ff[fcel_pkg::E_CFG], err_ff[fcel_pkg::E_OTP], err_ff[fcel_pkg::E_FRW]} &
    $past(ecc_2bit)) == $past(ecc_2bit))
    else $error("ECC source flag missing");
  a_code_access: assert property (!lock_ff && cf_rsv_hit |=>
    lock_ff && code_area_access_err_ff && err_ff[fcel_pkg::E_ILG])
    else $error("reserved code access not flagged");
  a_data_access: assert property (!lock_ff && (df_rsv_hit || cfgotp_rsv_hit) |=>
    lock_ff && data_area_access_err_ff && err_ff[fcel_pkg::E_ILG])
    else $error("reserved data access not flagged");
  a_otp_auth: assert property (!lock_ff && (otp_blk_hit || auth_missing) |=>
    lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("protected target not flagged");
  a_issue_area: assert property (cmd_area_rd || (cmd_first && read_mode) |=>
    lock_ff && err_ff[fcel_pkg::E_ILG])
    else $error("issue area misuse not flagged");
  a_clear_zeroes: assert property (unlock && !any_set |=>
    !lock_ff && err_ff == fcel_pkg::RST_ERR && !code_area_access_err_ff && !data_area_access_err_ff)
    else $error("clear left flags set");
  a_ready_read: assert property (reg_rd && reg_addr == fcel_pkg::OFS_SEQ_STAT |=>
    reg_rdata[fcel_pkg::RDY_BIT] == $past(seq_ready_flag))
    else $error("ready flag not reported");

  c_lock_then_clear: cover property ($rose(lock_ff) ##[1:20] $fell(lock_ff));
  c_locked_cmd: cover property (lock_ff && cmd_first && !unlock);
  c_suspend_ok: cover property (suspend_grant ##[1:50] cmd_resume);
  c_irq_raised: cover property ($rose(flash_access_err_irq));
  c_clear_unlocks: cover property (lock_ff && unlock);

endmodule
`default_nettype wire

// ---- fcel_cpu_model.sv ----
// Software-side model that issues command events to the sequencer
`default_nettype none
module fcel_cpu_model (
  // Clock
  input  wire logic        clk,
  // Sequencer state seen by software, and the rude switch
  input  wire logic        seq_ready_flag,
  input  wire logic        rude,
  // Event lines
  output var  logic [23:0] ev
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ev = '0;
  // One-cycle pulse; polite software never clears status while busy
  task automatic issue(input logic [23:0] m);
    @(posedge clk);
    if (m[6] && !seq_ready_flag && !rude) begin
      m[6] = 1'b0;
    end
    ev <= m;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the flash command error-lock block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, reg_wr, reg_rd, rude, is_dma, bc_dir, ready, busy, en;
  logic        locked, irq, rej, sgrant, abort, rmode, hve;
  logic [7:0]  reg_addr, last_data;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] ev, sa, ea;
  int          error_cnt, checks_done;
  // --------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------
  fcel_cpu_model cpu (.clk(clk), .seq_ready_flag(ready), .rude(rude), .ev(ev));
  fcel_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_first(ev[0]), .cmd_undef(ev[1]), .cmd_last(ev[2]),
    .cmd_last_data(last_data), .cmd_is_dma(is_dma), .cmd_n_bad(ev[3]), .cmd_mode_bad(ev[4]),
    .cmd_blank_chk(ev[5]), .blank_check_direction(bc_dir), .cmd_start_addr_reg(sa), .cmd_end_addr_reg(ea),
    .cmd_status_clr(ev[6]), .cmd_force_stop(ev[7]), .cmd_suspend(ev[8]), .cmd_resume(ev[9]),
    .cmd_area_rd(ev[10]), .cf_rsv_hit(ev[11]), .df_rsv_hit(ev[12]), .cfgotp_rsv_hit(ev[13]),
    .otp_blk_hit(ev[14]), .auth_missing(ev[15]), .erase_fail(ev[16]), .erase_lock_hit(ev[17]),
    .prog_fail(ev[18]), .prog_lock_hit(ev[19]), .ecc_2bit(ev[23:20]), .seq_ready_flag(ready),
    .op_busy(busy), .cmd_locked_flag(locked), .flash_access_err_irq(irq), .pe_reject(rej),
    .suspend_grant(sgrant), .op_abort(abort), .read_mode(rmode), .hv_enable_ctrl_bit(hve));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    wr(fcel_pkg::OFS_IRQ_EN, 32'(en) << fcel_pkg::IRQ_EN_BIT);
    wr(fcel_pkg::OFS_MODE, 32'(fcel_pkg::MODE_CODE));
  endtask
  // Expected {code access, data access, error flags} per error case
  function automatic logic [9:0] exp_of(int k);
    case (k)
      1: return (last_data != fcel_pkg::LAST_CODE && !is_dma) ? 10'h001 : 10'h000;
      4: return ((!bc_dir && sa > ea) || (bc_dir && sa < ea)) ? 10'h001 : 10'h000;
      6: return 10'h201;
      7, 8: return 10'h101;
      11, 12: return 10'(1) << fcel_pkg::E_ERS;
      13, 14: return 10'(1) << fcel_pkg::E_PRG;
      15: return 10'(1) << fcel_pkg::E_FRW;
      16: return 10'(1) << fcel_pkg::E_OTP;
      17: return 10'(1) << fcel_pkg::E_CFG;
      18: return 10'(1) << fcel_pkg::E_TBL;
      default: return 10'(1) << fcel_pkg::E_ILG;
    endcase
  endfunction
  function automatic logic [23:0] ev_of(int k);
    if (k == 0) return 24'h000003;
    if (k < 5) return 24'h1 << (k + 1);
    if (k == 5) return 24'h000400;
    return 24'h1 << (k + 5);
  endfunction
  task automatic chk_state(input logic [9:0] e, input logic lk);
    logic [31:0] d;
    chk({30'h0, irq, locked}, {30'h0, lk & en, lk});
    chk({31'h0, rej}, {31'h0, lk});
    rd(fcel_pkg::OFS_SEQ_STAT, d);
    chk(d & 32'h0000_80FF, {16'h0, ready, 7'h0, e[7:0]});
    rd(fcel_pkg::OFS_ACC_STAT, d);
    chk(d & 32'h0000_0098, {24'h0, e[9], 2'b0, lk, e[8], 3'b0});
  endtask
  task automatic recover(input logic [9:0] e);
    #1;
    if (e[9] | e[8]) begin
      cpu.issue(24'h000080);
      chk_state(e | 10'h001, 1'b1);
      do_reset();
    end else begin
      cpu.issue(ready ? 24'h000040 : 24'h000080);
      chk_state(10'h000, 1'b0);
    end
  endtask
  // Combinational outputs checked mid-cycle
  always @(negedge clk) begin
    if (rstn) begin
      chk({31'h0, abort}, {31'h0, ev[7]});
      chk({31'h0, sgrant}, {31'h0, ev[8] & busy & !locked});
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [15:0] mv;
    logic [9:0]  e;
    int          k;
    {rstn, reg_wr, reg_rd, rude, is_dma, bc_dir, busy} = '0;
    {reg_addr, reg_wdata, last_data, sa, ea} = '0;
    ready = 1'b1;
    en = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(32'h531A87E6));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({31'h0, rmode}, 32'h1);
    wr(fcel_pkg::OFS_ACC_STAT, 32'hFFFF_FFFF);
    rd(8'h20, d);
    chk(d, 32'h0);
    chk_state(10'h000, 1'b0);
    do_reset();
    for (int i = 0; i < 40; i++) begin
      k = (i < 19) ? i : int'($urandom_range(18));
      en = 1'($urandom_range(1));
      is_dma <= 1'($urandom_range(1));
      last_data <= $urandom_range(1) ? fcel_pkg::LAST_CODE : 8'($urandom);
      bc_dir <= 1'($urandom_range(1));
      sa <= 24'($urandom_range(3));
      ea <= 24'($urandom_range(3));
      ready <= 1'b1;
      wr(fcel_pkg::OFS_IRQ_EN, 32'(en) << fcel_pkg::IRQ_EN_BIT);
      cpu.issue(ev_of(k));
      e = exp_of(k);
      chk_state(e, |e);
      if (|e) begin
        busy <= 1'b1;
        cpu.issue(24'h000100);
        chk_state(e | 10'h001, 1'b1);
        ready <= 1'b0;
        rude <= 1'b1;
        cpu.issue(24'h000040);
        chk_state(e | 10'h001, 1'b1);
        {rude, busy} <= 2'b00;
        e = e | 10'h001;
      end
      ready <= 1'($urandom_range(1));
      recover(e);
    end
    for (int i = 0; i < 8; i++) begin
      mv = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0001 : (i == 2) ? 16'h0080 : 16'($urandom);
      wr(fcel_pkg::OFS_MODE, {16'h0, mv});
      e = (mv inside {fcel_pkg::MODE_READ, fcel_pkg::MODE_CODE, fcel_pkg::MODE_DATA}) ? 10'h000 : 10'h001;
      chk({31'h0, rmode}, {31'h0, mv == fcel_pkg::MODE_READ});
      chk_state(e, e[0]);
      recover(e);
    end
    wr(fcel_pkg::OFS_MODE, 32'(fcel_pkg::MODE_CODE));
    for (int i = 0; i < 2; i++) begin
      busy <= 1'b1;
      cpu.issue(24'h000100);
      busy <= 1'b0;
      if (i == 1) wr(fcel_pkg::OFS_MODE, 32'(fcel_pkg::MODE_DATA));
      cpu.issue(24'h000200);
      chk_state(10'(i), i == 1);
      recover(10'(i));
    end
    wr(fcel_pkg::OFS_HVE, 32'h1);
    chk({31'h0, hve}, 32'h1);
    {busy, ready} <= 2'b10;
    wr(fcel_pkg::OFS_HVE, 32'h0);
    @(posedge clk);
    {busy, ready} <= 2'b01;
    #1;
    e = 10'(1) << fcel_pkg::E_WE;
    chk_state(e, 1'b1);
    recover(e);
    wr(fcel_pkg::OFS_MODE, 32'(fcel_pkg::MODE_READ));
    cpu.issue(24'h000001);
    chk_state(10'h001, 1'b1);
    recover(10'h001);
    give_verdict();
  end
endmodule
`default_nettype wire
